// File: cief_params.svh
//==================================================================
// Function
// RULE_01: Timer-zero enable gates the timer interrupt
// RULE_02: Enable bit 4 gates external pin interrupt
// RULE_03: Enable bit 3 gates port change interrupt
// RULE_04: Port flag sets when watched pins change
// RULE_05: Persisting mismatch keeps setting port flag
// RULE_06: Port read relatches pins; clear by write
// RULE_07: Flags set regardless of any enable
// RULE_08: Global enable bit 7 gates all interrupts
// RULE_09: Timer and external flags sticky until cleared
//==================================================================
`ifndef CIEF_PARAMS_SVH
`define CIEF_PARAMS_SVH

// Register byte offsets
`define CIEF_OFS_CTRL   8'h00
`define CIEF_OFS_STAT   8'h04
`define CIEF_OFS_MASK   8'h08
`define CIEF_OFS_PORT   8'h0C
`define CIEF_OFS_CFG    8'h10

// Control register bit positions
`define CIEF_B_GIE      7
`define CIEF_B_PEIE     6
`define CIEF_B_TMR_EN   5
`define CIEF_B_EXT_EN   4
`define CIEF_B_PORT_EN  3
`define CIEF_B_TMR_F    2
`define CIEF_B_EXT_F    1
`define CIEF_B_PORT_F   0

// Config register bit position
`define CIEF_B_EDGE_SEL 0

// Reset values and bus answers
`define CIEF_CTRL_RST   8'h00
`define CIEF_RESP_OKAY  2'h0
`define CIEF_RESP_SLV   2'h2

`endif

// File: cief_pkg.sv
//==================================================================
// Types shared by the interrupt enable and flag block
//==================================================================
package cief_pkg;

  // Per-source and global enables
  typedef struct packed {
    logic global_irq_enable;
    logic periph_irq_enable;
    logic timer_zero_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
  } cief_enable_s;

  // Latched interrupt flags
  typedef struct packed {
    logic timer_zero_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } cief_flag_s;

  // Upper port pin group
  typedef logic [3:0] cief_pins_t;

endpackage

// File: cief_top.sv
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "cief_params.svh"

module cief_top
  import cief_pkg::*;
#(
  parameter int ADDR_W = 8               // Bus address width
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // Interrupt sources
  input  wire logic        i_timer_zero_overflow,
  input  wire logic        i_ext_irq_pin,
  input  wire cief_pins_t  i_monitored_upper_pins,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Interrupt request to the core
  output logic             o_irq
);

  //================================================================
  // Elaboration checks
  //================================================================
  // Offsets need at least eight address bits
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  //================================================================
  // State
  //================================================================
  cief_enable_s     en;          // Enables
  cief_enable_s     next_en;     // Enables after this edge
  cief_flag_s       flg;         // Sticky flags
  cief_flag_s       next_flg;    // Flags after this edge
  cief_pins_t       port_latch;  // Last latched pin values
  logic             primed;      // Latch holds real pins
  logic             ext_pin_q;   // Previous external pin level
  logic             rise_sel;    // One picks rising edge
  logic [ADDR_W-1:0] aw_addr;    // Held write address
  logic [31:0]      w_data;      // Held write data
  logic             w_lane0;     // Held strobe of low byte

  //================================================================
  // Decode
  //================================================================
  logic             wr_fire;     // Both halves held, no answer
  logic             ar_fire;     // Read address taken
  logic             wr_ctrl;     // Write hits control
  logic             wr_stat;     // Write hits status
  logic             wr_mask;     // Write hits mask
  logic             wr_cfg;      // Write hits config
  logic             wr_ok;       // Write address mapped
  logic             rd_port;     // Read hits the port
  logic             rd_ok;       // Read address mapped
  logic [31:0]      rd_data;     // Read mux output
  logic             ext_evt;     // Selected edge on the pin
  logic             mismatch;    // Pins differ from latch
  logic [7:0]       ctrl_view;   // Control register image

  // Write runs once both channels were taken
  assign wr_fire = ~o_awready & ~o_wready & ~o_bvalid;
  assign ar_fire = i_arvalid & o_arready;

  // Only the low byte holds bits, so only lane 0 writes
  assign wr_ctrl = wr_fire & w_lane0
                 & (aw_addr[7:0] == `CIEF_OFS_CTRL);
  assign wr_stat = wr_fire & w_lane0
                 & (aw_addr[7:0] == `CIEF_OFS_STAT);
  assign wr_mask = wr_fire & w_lane0
                 & (aw_addr[7:0] == `CIEF_OFS_MASK);
  assign wr_cfg  = wr_fire & w_lane0
                 & (aw_addr[7:0] == `CIEF_OFS_CFG);

  // Port register is read only but a write is harmless
  assign wr_ok = (aw_addr[7:0] == `CIEF_OFS_CTRL)
               | (aw_addr[7:0] == `CIEF_OFS_STAT)
               | (aw_addr[7:0] == `CIEF_OFS_MASK)
               | (aw_addr[7:0] == `CIEF_OFS_PORT)
               | (aw_addr[7:0] == `CIEF_OFS_CFG);

  assign rd_port = i_araddr[7:0] == `CIEF_OFS_PORT;
  assign rd_ok   = (i_araddr[7:0] == `CIEF_OFS_CTRL)
                 | (i_araddr[7:0] == `CIEF_OFS_STAT)
                 | (i_araddr[7:0] == `CIEF_OFS_MASK)
                 | rd_port
                 | (i_araddr[7:0] == `CIEF_OFS_CFG);

  //================================================================
  // Event detection
  //================================================================
  // Edge chosen by the config bit
  assign ext_evt = rise_sel ? (i_ext_irq_pin & ~ext_pin_q)
                            : (~i_ext_irq_pin & ext_pin_q);

  // Any watched pin off its latched value
  assign mismatch = primed
                  & (i_monitored_upper_pins != port_latch); // [RULE_04]

  // Control image in its documented bit order
  assign ctrl_view = {en.global_irq_enable,
                      en.periph_irq_enable,
                      en.timer_zero_irq_enable,
                      en.ext_pin_irq_enable,
                      en.port_change_irq_enable,
                      flg.timer_zero_overflow_flag,
                      flg.ext_pin_irq_flag,
                      flg.port_change_flag};

  //================================================================
  // Next enables
  //================================================================
  always_comb begin
    next_en = en;
    if (wr_ctrl) begin
      next_en.global_irq_enable      = w_data[`CIEF_B_GIE];
      next_en.periph_irq_enable      = w_data[`CIEF_B_PEIE];
      next_en.timer_zero_irq_enable  = w_data[`CIEF_B_TMR_EN];
      next_en.ext_pin_irq_enable     = w_data[`CIEF_B_EXT_EN];
      next_en.port_change_irq_enable = w_data[`CIEF_B_PORT_EN];
    end else if (wr_mask) begin
      // Mask shares the status layout
      next_en.timer_zero_irq_enable  = w_data[`CIEF_B_TMR_F];
      next_en.ext_pin_irq_enable     = w_data[`CIEF_B_EXT_F];
      next_en.port_change_irq_enable = w_data[`CIEF_B_PORT_F];
    end
  end

  //================================================================
  // Next flags
  //================================================================
  // Software write goes first, then events OR in, so a set
  // in the clearing cycle is never lost.
  always_comb begin
    next_flg = flg;
    if (wr_ctrl) begin
      // Writing zero clears, writing one sets
      next_flg.timer_zero_overflow_flag = w_data[`CIEF_B_TMR_F];
      next_flg.ext_pin_irq_flag         = w_data[`CIEF_B_EXT_F];
      next_flg.port_change_flag         = w_data[`CIEF_B_PORT_F];
    end else if (wr_stat) begin
      // Alias view clears on written ones
      if (w_data[`CIEF_B_TMR_F])
        next_flg.timer_zero_overflow_flag = 1'b0;
      if (w_data[`CIEF_B_EXT_F])
        next_flg.ext_pin_irq_flag = 1'b0;
      if (w_data[`CIEF_B_PORT_F])
        next_flg.port_change_flag = 1'b0;
    end
    // Sources set flags whatever the enables say
    if (i_timer_zero_overflow)
      next_flg.timer_zero_overflow_flag = 1'b1; // [RULE_07] [RULE_09]
    if (ext_evt)
      next_flg.ext_pin_irq_flag = 1'b1;         // [RULE_07] [RULE_09]
    // A standing mismatch re-sets it every cycle
    if (mismatch)
      next_flg.port_change_flag = 1'b1;         // [RULE_05] [RULE_06]
  end

  //================================================================
  // Enable and flag registers
  //================================================================
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en  <= cief_enable_s'(5'h00);
      flg <= cief_flag_s'(3'h0);
    end else begin
      en  <= next_en;
      flg <= next_flg;
    end
  end

  //================================================================
  // Config register
  //================================================================
  // Falling edge chosen after reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_sel <= 1'b0;
    end else if (wr_cfg) begin
      rise_sel <= w_data[`CIEF_B_EDGE_SEL];
    end
  end

  //================================================================
  // Pin history
  //================================================================
  // Latch primes from the pins on the first edge after reset,
  // so no false change is flagged out of reset.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_latch <= cief_pins_t'(4'h0);
      primed     <= 1'b0;
      ext_pin_q  <= 1'b0;
    end else begin
      ext_pin_q <= i_ext_irq_pin;
      primed    <= 1'b1;
      if (!primed || (ar_fire && rd_port)) begin
        port_latch <= i_monitored_upper_pins;   // [RULE_06]
      end
    end
  end

  //================================================================
  // Interrupt output
  //================================================================
  // One level, gated first per source, then globally
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= en.global_irq_enable                      // [RULE_08]
             & ((flg.timer_zero_overflow_flag
                 & en.timer_zero_irq_enable)             // [RULE_01]
              | (flg.ext_pin_irq_flag
                 & en.ext_pin_irq_enable)                // [RULE_02]
              | (flg.port_change_flag
                 & en.port_change_irq_enable));          // [RULE_03]
    end
  end

  //================================================================
  // Write channels
  //================================================================
  // Each ready drops when its item is taken and rises again
  // once the answer is taken, so either order of arrival works.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `CIEF_RESP_OKAY;
      aw_addr   <= '0;
      w_data    <= 32'h0;
      w_lane0   <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_addr   <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_data   <= i_wdata;
        w_lane0  <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? `CIEF_RESP_OKAY : `CIEF_RESP_SLV;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  //================================================================
  // Read mux
  //================================================================
  // Unmapped addresses read as zero with an error answer
  always_comb begin
    rd_data = 32'h0;
    unique case (i_araddr[7:0])
      `CIEF_OFS_CTRL: rd_data[7:0] = ctrl_view;
      `CIEF_OFS_STAT: rd_data[2:0] = flg;
      `CIEF_OFS_MASK: rd_data[2:0] = {en.timer_zero_irq_enable,
                                      en.ext_pin_irq_enable,
                                      en.port_change_irq_enable};
      `CIEF_OFS_PORT: rd_data[3:0] = i_monitored_upper_pins;
      `CIEF_OFS_CFG:  rd_data[`CIEF_B_EDGE_SEL] = rise_sel;
      default:        rd_data      = 32'h0;
    endcase
  end

  //================================================================
  // Read channel
  //================================================================
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= `CIEF_RESP_OKAY;
    end else if (ar_fire) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_data;
      o_rresp   <= rd_ok ? `CIEF_RESP_OKAY : `CIEF_RESP_SLV;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule

// File: cief_top_checker.sv
`timescale 1ns/100ps
`include "cief_params.svh"

//==============================================================
// Port checks of the interrupt enable and flag block
//==============================================================
module cief_top_checker
  import cief_pkg::*;
#(
  parameter int ADDR_W = 8  // Bus address width
) (
  input wire logic              i_clk_sys,
  input wire logic              i_arst_n,
  input wire cief_pins_t        i_monitored_upper_pins,
  input wire logic              i_awvalid,
  input wire logic              o_awready,
  input wire logic              i_wvalid,
  input wire logic              o_wready,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [31:0]       o_rdata,
  input wire logic [1:0]        o_rresp,
  input wire logic              o_rvalid,
  input wire logic              i_rready
);
  localparam logic [ADDR_W-1:0] HOLE = 'h14;  // First unmapped word

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  // Answers must stand until the master takes them
  a_bresp_stands: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write answer not held");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read answer not held");
  // Single outstanding request per direction
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answer open");
  a_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answer open");
  // Answer latency is fixed by the slave logic
  a_write_answered: assert property (i_awvalid && o_awready &&
    i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write not answered");
  a_read_answered: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  a_ready_returns: assert property (o_bvalid && i_bready |=>
    o_awready && o_wready) else $error("write side not free again");
  // Port read gives the pins seen at the address edge
  a_port_readback: assert property (
    i_arvalid && o_arready && i_araddr == `CIEF_OFS_PORT |=>
    o_rdata == {28'h0, $past(i_monitored_upper_pins)})
    else $error("port read data wrong");
  // Holes answer with an error and zero data
  a_hole_read: assert property (i_arvalid && o_arready &&
    i_araddr == HOLE |=> o_rresp == `CIEF_RESP_SLV && o_rdata == 32'h0)
    else $error("unmapped read not refused");

  c_write_done: cover property (o_bvalid && i_bready);
  c_read_done: cover property (o_rvalid && i_rready);
  c_slave_error: cover property (o_rvalid && o_rresp == `CIEF_RESP_SLV);
endmodule

bind cief_top cief_top_checker #(.ADDR_W(ADDR_W)) i_checker (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_monitored_upper_pins(i_monitored_upper_pins),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid), .i_rready(i_rready)
);

// File: test_cief_top.sv
`timescale 1ns/100ps
`include "cief_params.svh"

//==============================================================
// Self-checking bench of the interrupt enable and flag block
//==============================================================
module test_cief_top
  import cief_pkg::*;
;
  logic        clk_sys = 1'b0, arst_n = 1'b0;  // Clock, reset
  logic        tmr_ovf = 1'b0;                 // Timer overflow pulse
  logic        ext_pin = 1'b1;                 // Idles high: falling arms
  cief_pins_t  pins    = 4'h0;                 // Watched upper pins
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata   = 32'h0, rdata, rd;     // rd: last read word
  logic [3:0]  strb    = 4'hF;                 // Write byte lanes
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, resp;             // resp: last answer code
  int          bad_count = 0, checks_done = 0;

  always #2.5 clk_sys = ~clk_sys;

  cief_top i_dut (
    .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_timer_zero_overflow(tmr_ovf),
    .i_ext_irq_pin(ext_pin), .i_monitored_upper_pins(pins),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(strb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_irq(irq));

  //============================================================
  // Checking and closing
  //============================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A bus answer that never comes ends the run as a failure
  task automatic hang();
    bad_count++;
    $display("unexpected at %0t: bus answer missing", $time);
    conclude();
  endtask

  //============================================================
  // AXI4-Lite master: address and data offered together
  //============================================================
  // A lag keeps the answer ready low that long, so answers must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int lag = 0);
    bit done = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        resp = bresp;
        done = 1;
      end else if (n + 1 >= lag) begin
        bready <= 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic rdr(input logic [7:0] a, input int lag = 0);
    bit done = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
        done = 1;
      end else if (n + 1 >= lag) begin
        rready <= 1'b1;
      end
    end
    if (!done) hang();
  endtask

  //============================================================
  // Event sources and expectations
  //============================================================
  function automatic logic [31:0] bit_of(input int s);
    return 32'h1 << s;
  endfunction

  // Source 0 port change, 1 external pin, 2 timer overflow
  task automatic fire(input int s);
    @(posedge clk_sys);
    case (s)
      0: pins <= pins ^ cief_pins_t'($urandom_range(15, 1));
      1: ext_pin <= ~ext_pin;
      default: tmr_ovf <= 1'b1;
    endcase
    @(posedge clk_sys);
    tmr_ovf <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // Interrupt output is registered: let it settle before looking
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  //============================================================
  // Main sequence
  //============================================================
  initial begin
    void'($urandom(76071));
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdr(`CIEF_OFS_CTRL);
    chk(rd, {24'h0, `CIEF_CTRL_RST});
    for (int s = 0; s < 3; s++) begin
      wr(`CIEF_OFS_CTRL, 32'h80);  // Global on, sources masked
      fire(s);
      rdr(`CIEF_OFS_STAT);
      chk(rd, bit_of(s));
      irq_is(1'b0);
      wr(`CIEF_OFS_MASK, bit_of(s));
      chk({30'h0, resp}, {30'h0, `CIEF_RESP_OKAY});
      irq_is(1'b1);
      wr(`CIEF_OFS_CTRL, bit_of(s + 3) | bit_of(s));
      rdr(`CIEF_OFS_CTRL);
      chk(rd, bit_of(s + 3) | bit_of(s));
      irq_is(1'b0);
      wr(`CIEF_OFS_STAT, bit_of(s));
      rdr(`CIEF_OFS_STAT);
      chk(rd, (s == 0) ? 32'h1 : 32'h0);
      if (s == 0) begin
        rdr(`CIEF_OFS_PORT);
        chk(rd, {28'h0, pins});
        wr(`CIEF_OFS_STAT, 32'h1);
        rdr(`CIEF_OFS_STAT);
        chk(rd, 32'h0);
      end
    end
    // Rising edge is ignored until it is selected
    fire(1);
    rdr(`CIEF_OFS_STAT);
    chk(rd, 32'h0);
    wr(`CIEF_OFS_CFG, 32'h1);
    fire(1);
    rdr(`CIEF_OFS_STAT);
    chk(rd, 32'h0);
    fire(1);
    rdr(`CIEF_OFS_STAT);
    chk(rd, 32'h2);
    // Unmapped word: error answer, zero data
    wr(8'h14, $urandom, 4);
    chk({30'h0, resp}, {30'h0, `CIEF_RESP_SLV});
    rdr(8'h14, 3);
    chk({30'h0, resp}, {30'h0, `CIEF_RESP_SLV});
    chk(rd, 32'h0);
    // Low lane off: the write is dropped but still answered
    strb <= 4'hE;
    wr(`CIEF_OFS_CTRL, 32'h0);
    chk({30'h0, resp}, {30'h0, `CIEF_RESP_OKAY});
    strb <= 4'hF;
    rdr(`CIEF_OFS_CTRL);
    chk(rd, 32'h22);
    conclude();
  end
endmodule
